// ### logic/pinthr_params.svh
// Register indices, field positions, reset values and fixed levels of the pin and threshold bank
`ifndef PINTHR_PARAMS_SVH
`define PINTHR_PARAMS_SVH

// Register indices; byte address on the bus is four times the index
`define PINTHR_IDX_FAULT_STATUS 8'h63
`define PINTHR_IDX_DIRECTION 8'h78
`define PINTHR_IDX_OUT_LEVEL 8'h79
`define PINTHR_IDX_PULLUP 8'h7a
`define PINTHR_IDX_PULLDOWN 8'h7b
`define PINTHR_IDX_IN_LEVEL 8'h7c
`define PINTHR_IDX_FAULT_SETUP 8'h7d
`define PINTHR_IDX_UNLOCK_KEY 8'h82
`define PINTHR_IDX_COMP_UNDER 8'h8c
`define PINTHR_IDX_COMP_OVER 8'h8d
`define PINTHR_IDX_CELL_UNDER 8'h8e
`define PINTHR_IDX_CELL_OVER 8'h90
`define PINTHR_IDX_AUX_ZERO_UNDER 8'h92

// Field positions
`define PINTHR_POLARITY_BIT 6
`define PINTHR_CODE8_MSB 7
`define PINTHR_CODE8_LSB 1
`define PINTHR_SHIFT_BIT 0
`define PINTHR_CODE16_MSB 15
`define PINTHR_CODE16_LSB 2

// Reset values
`define PINTHR_RST_PINS 6'h00
`define PINTHR_RST_POLARITY 1'h0
`define PINTHR_RST_CODE7 7'h00
`define PINTHR_RST_SHIFT 1'h0
`define PINTHR_RST_CODE14 14'h0000

// Comparator threshold levels in millivolts
`define PINTHR_LOW_RANGE_BASE_MV 13'h2bc
`define PINTHR_HIGH_RANGE_BASE_MV 13'h7d0
`define PINTHR_STEP_MV 13'h019

`endif

// ### logic/pinthr_pkg.sv
// Types shared by the pin and threshold register bank
package pinthr_pkg;
  typedef logic [5:0] pinthr_pins_t;
  typedef logic [6:0] pinthr_code7_t;
  typedef logic [13:0] pinthr_code14_t;
  typedef logic [12:0] pinthr_mv_t;
  typedef logic [15:0] pinthr_sample_t;
endpackage : pinthr_pkg

// ### logic/pinthr_regs.sv
// Pin control, fault input and voltage threshold register bank on a classic Wishbone slave
`timescale 1ns/1ps

`include "pinthr_params.svh"

module pinthr_regs #(
  parameter int PIN_COUNT = 6,
  parameter logic [31:0] UNLOCK_KEY = 32'h5a5a_0f0f // Arbitrary value, set per product
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Two-way general-purpose pins
  input wire pinthr_pkg::pinthr_pins_t pin_in_bits,
  output pinthr_pkg::pinthr_pins_t pin_out_bits,
  output pinthr_pkg::pinthr_pins_t pin_oe_b,
  output pinthr_pkg::pinthr_pins_t pin_pullup_bits,
  output pinthr_pkg::pinthr_pins_t pin_pulldown_bits,
  // Programming unlock level
  output logic nvm_unlocked,
  // Protector comparator trip levels in millivolts
  output pinthr_pkg::pinthr_mv_t comp_under_level_mv,
  output pinthr_pkg::pinthr_mv_t comp_over_level_mv,
  // Conversion results from the converter, same clock
  input wire logic conv_valid,
  input wire logic conv_is_aux_zero,
  input wire pinthr_pkg::pinthr_sample_t conv_result,
  // One-cycle threshold crossing pulses
  output logic cell_under_fault,
  output logic cell_over_fault,
  output logic aux_zero_under_fault
);
  import pinthr_pkg::*;

  // The pin logic is written for exactly six pins
  if (PIN_COUNT != 6) begin : g_bad_pins
    $error("pinthr_regs serves exactly six pins");
  end

  // Header field positions must match the code widths that the types carry
  if (`PINTHR_CODE8_MSB - `PINTHR_CODE8_LSB != 6 || `PINTHR_CODE16_MSB - `PINTHR_CODE16_LSB != 13) begin : g_bad_fields
    $error("pinthr_regs field positions do not match the code widths");
  end

  // Byte-lane merge of a 16-bit register value with write data
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data, input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = data[7:0];
    end
    if (sel[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // Comparator trip level: base of the chosen range plus one step per code
  function automatic pinthr_mv_t level_mv(input pinthr_code7_t code, input logic high_range);
    pinthr_mv_t base;
    base = high_range ? `PINTHR_HIGH_RANGE_BASE_MV : `PINTHR_LOW_RANGE_BASE_MV;
    return base + ({6'h00, code} * `PINTHR_STEP_MV);
  endfunction : level_mv

  // Register state
  pinthr_pins_t dir_q, dir_d;
  pinthr_pins_t out_q, out_d;
  pinthr_pins_t pu_q, pu_d;
  pinthr_pins_t pd_q, pd_d;
  pinthr_pins_t oe_b_q, oe_b_d;
  pinthr_pins_t flt_sel_q, flt_sel_d;
  logic flt_pol_q, flt_pol_d;
  pinthr_pins_t flt_stat_q, flt_stat_d;
  logic unlock_q, unlock_d;
  pinthr_code7_t cmp_uv_code_q, cmp_uv_code_d;
  logic uv_shift_q, uv_shift_d;
  pinthr_code7_t cmp_ov_code_q, cmp_ov_code_d;
  logic ov_shift_q, ov_shift_d;
  pinthr_mv_t uv_mv_q, uv_mv_d;
  pinthr_mv_t ov_mv_q, ov_mv_d;
  pinthr_code14_t cell_under_register_q, cell_under_register_d;
  pinthr_code14_t cell_over_register_q, cell_over_register_d;
  pinthr_code14_t aux_zero_under_register_q, aux_zero_under_register_d;
  logic cell_under_register_hit_q, cell_under_register_hit_d;
  logic cell_over_register_hit_q, cell_over_register_hit_d;
  logic aux_zero_under_register_hit_q, aux_zero_under_register_hit_d;

  // Bus state
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  // Pin input synchroniser; the first stage feeds only the second
  pinthr_pins_t pin_meta_q, pin_meta_d;
  pinthr_pins_t pin_sync_q, pin_sync_d;

  // Decode helpers
  logic [7:0] idx;
  logic wr_go;
  logic [15:0] cur16;
  logic [15:0] new16;
  pinthr_pins_t flt_seen;

  // Low address bits are ignored: every register sits on a word boundary
  assign idx = wb_adr_i[9:2];
  // Write takes effect at the edge where the master samples ack high
  // A request dropped before ack therefore never half-applies a write
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  // Two flip-flops before any logic reads the pins; pads may change at any time
  always_comb begin
    pin_meta_d = pin_in_bits;
    pin_sync_d = pin_meta_q;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= `PINTHR_RST_PINS;
      pin_sync_q <= `PINTHR_RST_PINS;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
    end
  end

  // Fault level per pin, only on pins chosen as fault inputs; the pin's own drive still counts
  always_comb begin
    flt_seen = flt_sel_q & (flt_pol_q ? pin_sync_q : ~pin_sync_q);
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  // Registered read data costs a cycle but keeps wb_dat_o straight from a flip-flop
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d = 32'h0000_0000; // Unmapped and reserved read as zero
    case (idx)
      `PINTHR_IDX_FAULT_STATUS: rdat_d[5:0] = flt_stat_q;
      `PINTHR_IDX_DIRECTION: rdat_d[5:0] = dir_q;
      `PINTHR_IDX_OUT_LEVEL: rdat_d[5:0] = out_q;
      `PINTHR_IDX_PULLUP: rdat_d[5:0] = pu_q;
      `PINTHR_IDX_PULLDOWN: rdat_d[5:0] = pd_q;
      `PINTHR_IDX_IN_LEVEL: rdat_d[5:0] = pin_sync_q;
      `PINTHR_IDX_FAULT_SETUP: rdat_d[6:0] = {flt_pol_q, flt_sel_q};
      `PINTHR_IDX_UNLOCK_KEY: rdat_d = 32'h0000_0000;
      `PINTHR_IDX_COMP_UNDER: rdat_d[7:0] = {cmp_uv_code_q, uv_shift_q};
      `PINTHR_IDX_COMP_OVER: rdat_d[7:0] = {cmp_ov_code_q, ov_shift_q};
      `PINTHR_IDX_CELL_UNDER: rdat_d[15:0] = {cell_under_register_q, 2'h0};
      `PINTHR_IDX_CELL_OVER: rdat_d[15:0] = {cell_over_register_q, 2'h0};
      `PINTHR_IDX_AUX_ZERO_UNDER: rdat_d[15:0] = {aux_zero_under_register_q, 2'h0};
      default: rdat_d = 32'h0000_0000;
    endcase
    if (!ack_d) begin
      rdat_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'h0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Register writes; reserved bits are dropped on write
  always_comb begin
    dir_d = dir_q;
    out_d = out_q;
    pu_d = pu_q;
    pd_d = pd_q;
    flt_sel_d = flt_sel_q;
    flt_pol_d = flt_pol_q;
    unlock_d = unlock_q;
    cmp_uv_code_d = cmp_uv_code_q;
    uv_shift_d = uv_shift_q;
    cmp_ov_code_d = cmp_ov_code_q;
    ov_shift_d = ov_shift_q;
    cell_under_register_d = cell_under_register_q;
    cell_over_register_d = cell_over_register_q;
    aux_zero_under_register_d = aux_zero_under_register_q;
    cur16 = 16'h0000;
    new16 = 16'h0000;
    // Set wins over a clear arriving in the same cycle
    // Status is fed by a level, so clearing a lasting fault sees it set again
    flt_stat_d = flt_stat_q;
    if (wr_go && idx == `PINTHR_IDX_FAULT_STATUS && wb_sel_i[0]) begin
      flt_stat_d = flt_stat_q & ~wb_dat_i[5:0];
    end
    flt_stat_d = flt_stat_d | flt_seen;
    if (wr_go) begin
      case (idx)
        `PINTHR_IDX_DIRECTION: begin
          if (wb_sel_i[0]) begin
            dir_d = wb_dat_i[5:0];
          end
        end
        `PINTHR_IDX_OUT_LEVEL: begin
          if (wb_sel_i[0]) begin
            out_d = wb_dat_i[5:0];
          end
        end
        `PINTHR_IDX_PULLUP: begin
          if (wb_sel_i[0]) begin
            pu_d = wb_dat_i[5:0];
          end
        end
        `PINTHR_IDX_PULLDOWN: begin
          if (wb_sel_i[0]) begin
            pd_d = wb_dat_i[5:0];
          end
        end
        `PINTHR_IDX_FAULT_SETUP: begin
          if (wb_sel_i[0]) begin
            flt_sel_d = wb_dat_i[5:0];
            flt_pol_d = wb_dat_i[`PINTHR_POLARITY_BIT];
          end
        end
        `PINTHR_IDX_UNLOCK_KEY: begin
          // A partial or wrong key relocks, so the key cannot be built up piecewise
          unlock_d = (wb_sel_i == 4'hf) && (wb_dat_i == UNLOCK_KEY);
        end
        `PINTHR_IDX_COMP_UNDER: begin
          if (wb_sel_i[0]) begin
            cmp_uv_code_d = wb_dat_i[`PINTHR_CODE8_MSB:`PINTHR_CODE8_LSB];
            uv_shift_d = wb_dat_i[`PINTHR_SHIFT_BIT];
          end
        end
        `PINTHR_IDX_COMP_OVER: begin
          if (wb_sel_i[0]) begin
            cmp_ov_code_d = wb_dat_i[`PINTHR_CODE8_MSB:`PINTHR_CODE8_LSB];
            ov_shift_d = wb_dat_i[`PINTHR_SHIFT_BIT];
          end
        end
        `PINTHR_IDX_CELL_UNDER: begin
          cur16 = {cell_under_register_q, 2'h0};
          new16 = merge16(cur16, wb_dat_i, wb_sel_i);
          cell_under_register_d = new16[`PINTHR_CODE16_MSB:`PINTHR_CODE16_LSB];
        end
        `PINTHR_IDX_CELL_OVER: begin
          cur16 = {cell_over_register_q, 2'h0};
          new16 = merge16(cur16, wb_dat_i, wb_sel_i);
          cell_over_register_d = new16[`PINTHR_CODE16_MSB:`PINTHR_CODE16_LSB];
        end
        `PINTHR_IDX_AUX_ZERO_UNDER: begin
          cur16 = {aux_zero_under_register_q, 2'h0};
          new16 = merge16(cur16, wb_dat_i, wb_sel_i);
          aux_zero_under_register_d = new16[`PINTHR_CODE16_MSB:`PINTHR_CODE16_LSB];
        end
        default: begin
          unlock_d = unlock_q;
        end
      endcase
    end
  end

  // Pin drive follows direction; fault selection never blocks the drive
  always_comb begin
    oe_b_d = ~dir_d;
  end

  // Trip levels recomputed from the next codes so they track writes without lag
  // Over range is inverted against under range, hence the flipped shift bit
  always_comb begin
    uv_mv_d = level_mv(cmp_uv_code_d, uv_shift_d);
    ov_mv_d = level_mv(cmp_ov_code_d, ~ov_shift_d);
  end

  // Threshold checks; the 14-bit code sits on the top of the 16-bit result
  // Strict compares: a result equal to its threshold raises no fault
  always_comb begin
    cell_under_register_hit_d = conv_valid & ~conv_is_aux_zero & (conv_result < {cell_under_register_q, 2'h0});
    cell_over_register_hit_d = conv_valid & ~conv_is_aux_zero & (conv_result > {cell_over_register_q, 2'h0});
    aux_zero_under_register_hit_d = conv_valid & conv_is_aux_zero & (conv_result < {aux_zero_under_register_q, 2'h0});
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_q <= `PINTHR_RST_PINS;
      out_q <= `PINTHR_RST_PINS;
      pu_q <= `PINTHR_RST_PINS;
      pd_q <= `PINTHR_RST_PINS;
      oe_b_q <= ~`PINTHR_RST_PINS;
      flt_sel_q <= `PINTHR_RST_PINS;
      flt_pol_q <= `PINTHR_RST_POLARITY;
      flt_stat_q <= `PINTHR_RST_PINS;
      unlock_q <= 1'h0;
      cmp_uv_code_q <= `PINTHR_RST_CODE7;
      uv_shift_q <= `PINTHR_RST_SHIFT;
      cmp_ov_code_q <= `PINTHR_RST_CODE7;
      ov_shift_q <= `PINTHR_RST_SHIFT;
      uv_mv_q <= `PINTHR_LOW_RANGE_BASE_MV;
      ov_mv_q <= `PINTHR_HIGH_RANGE_BASE_MV;
      cell_under_register_q <= `PINTHR_RST_CODE14;
      cell_over_register_q <= `PINTHR_RST_CODE14;
      aux_zero_under_register_q <= `PINTHR_RST_CODE14;
      cell_under_register_hit_q <= 1'h0;
      cell_over_register_hit_q <= 1'h0;
      aux_zero_under_register_hit_q <= 1'h0;
    end else begin
      dir_q <= dir_d;
      out_q <= out_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
      oe_b_q <= oe_b_d;
      flt_sel_q <= flt_sel_d;
      flt_pol_q <= flt_pol_d;
      flt_stat_q <= flt_stat_d;
      unlock_q <= unlock_d;
      cmp_uv_code_q <= cmp_uv_code_d;
      uv_shift_q <= uv_shift_d;
      cmp_ov_code_q <= cmp_ov_code_d;
      ov_shift_q <= ov_shift_d;
      uv_mv_q <= uv_mv_d;
      ov_mv_q <= ov_mv_d;
      cell_under_register_q <= cell_under_register_d;
      cell_over_register_q <= cell_over_register_d;
      aux_zero_under_register_q <= aux_zero_under_register_d;
      cell_under_register_hit_q <= cell_under_register_hit_d;
      cell_over_register_hit_q <= cell_over_register_hit_d;
      aux_zero_under_register_hit_q <= aux_zero_under_register_hit_d;
    end
  end

  // Outputs straight from flip-flops; both pulls on one pin is software's care
  // Pull enables pass through unmasked; blocking a clash here would hide a software fault
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pin_out_bits = out_q;
  assign pin_oe_b = oe_b_q;
  assign pin_pullup_bits = pu_q;
  assign pin_pulldown_bits = pd_q;
  assign nvm_unlocked = unlock_q;
  assign comp_under_level_mv = uv_mv_q;
  assign comp_over_level_mv = ov_mv_q;
  assign cell_under_fault = cell_under_register_hit_q;
  assign cell_over_fault = cell_over_register_hit_q;
  assign aux_zero_under_fault = aux_zero_under_register_hit_q;

endmodule : pinthr_regs

// ### dv/pinthr_regs_asserts.sv
// Concurrent checks on the ports of the pin and threshold register bank
`timescale 1ns/1ps
module pinthr_regs_asserts #(
  parameter logic [31:0] UNLOCK_KEY = 32'h5a5a_0f0f // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire pinthr_pkg::pinthr_pins_t pin_out_bits,
  input wire pinthr_pkg::pinthr_pins_t pin_oe_b,
  input wire pinthr_pkg::pinthr_pins_t pin_pullup_bits,
  input wire pinthr_pkg::pinthr_pins_t pin_pulldown_bits,
  input wire logic nvm_unlocked,
  input wire pinthr_pkg::pinthr_mv_t comp_under_level_mv,
  input wire logic conv_valid,
  input wire logic conv_is_aux_zero,
  input wire logic cell_under_fault,
  input wire logic aux_zero_under_fault
);
  import pinthr_pkg::*;
  // A write lands at the edge that sees ack; low lane carries the byte registers
  wire logic wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  wire logic [7:0] ix = wb_adr_i[9:2];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  a_dir_write: assert property (wr && ix == 8'h78 |=> pin_oe_b == ~$past(wb_dat_i[5:0]))
    else $error("direction write not applied");
  a_out_write: assert property (wr && ix == 8'h79 |=> pin_out_bits == $past(wb_dat_i[5:0]))
    else $error("output level write not applied");
  a_pullup_write: assert property (wr && ix == 8'h7a |=> pin_pullup_bits == $past(wb_dat_i[5:0]))
    else $error("pull-up write not applied");
  a_pulldown_write: assert property (wr && ix == 8'h7b |=> pin_pulldown_bits == $past(wb_dat_i[5:0]))
    else $error("pull-down write not applied");
  a_key_reads_zero: assert property (wb_ack_o && ix == 8'h82 |-> wb_dat_o == 32'h0)
    else $error("unlock key returned nonzero data");
  a_reserved_zero: assert property (wb_ack_o && ix inside {[8'h78:8'h7c]} |-> wb_dat_o[31:6] == 26'h0)
    else $error("reserved pin register bits not zero");
  a_under_level: assert property (wr && ix == 8'h8c |=> comp_under_level_mv ==
    ($past(wb_dat_i[0]) ? 13'h7d0 : 13'h2bc) + 13'h019 * $past(wb_dat_i[7:1]))
    else $error("undervoltage trip level wrong");
  a_unlock_cause: assert property ($rose(nvm_unlocked) |->
    $past(wr && ix == 8'h82 && wb_sel_i == 4'hf && wb_dat_i == UNLOCK_KEY))
    else $error("unlock without a full correct key write");
  a_cell_fault_src: assert property (cell_under_fault |-> $past(conv_valid && !conv_is_aux_zero))
    else $error("cell fault without a cell conversion");
  a_aux_fault_src: assert property (aux_zero_under_fault |-> $past(conv_valid && conv_is_aux_zero))
    else $error("aux fault without an aux conversion");
endmodule : pinthr_regs_asserts

bind pinthr_regs pinthr_regs_asserts #(.UNLOCK_KEY(UNLOCK_KEY)) i_pinthr_regs_asserts (.core_clk, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_out_bits,
  .pin_oe_b, .pin_pullup_bits, .pin_pulldown_bits, .nvm_unlocked, .comp_under_level_mv, .conv_valid,
  .conv_is_aux_zero, .cell_under_fault, .aux_zero_under_fault);

// ### dv/pinthr_regs_test.sv
// Self-checking bench for the pin and threshold register bank
`timescale 1ns/1ps
module pinthr_regs_test;
  import pinthr_pkg::*;
  localparam logic [31:0] KEY = 32'h1234_abcd; // Arbitrary value
  logic core_clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, cv = 0, caux = 0, s, ack, unl, cuf, cof, auf;
  logic [9:0] adr = '0;
  logic [3:0] sel = '0;
  logic [6:0] c;
  logic [31:0] wdat = '0, rdat, dout;
  pinthr_sample_t cres = '0;
  pinthr_pins_t pin_in = '0, pout, poe_b, pup, pdn;
  pinthr_mv_t lvl_u, lvl_o;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  pinthr_regs #(.UNLOCK_KEY(KEY)) i_pinthr_regs (.core_clk, .rst_b, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .pin_in_bits(pin_in), .pin_out_bits(pout), .pin_oe_b(poe_b), .pin_pullup_bits(pup),
    .pin_pulldown_bits(pdn), .nvm_unlocked(unl), .comp_under_level_mv(lvl_u), .comp_over_level_mv(lvl_o),
    .conv_valid(cv), .conv_is_aux_zero(caux), .conv_result(cres), .cell_under_fault(cuf),
    .cell_over_fault(cof), .aux_zero_under_fault(auf));
  initial forever #5 core_clk = ~core_clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Whole run needs under two hundred cycles; the ceiling leaves ample slack
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle; entered just after an edge, leaves one idle cycle behind; only the timeout ends a wait
  task automatic acc(input logic w, input logic [7:0] ix, input logic [3:0] se, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= se;
    wdat <= d;
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
    chk("ack", 0, ack); // Ack stands one cycle only
  endtask : acc
  task automatic rd(input string nm, input logic [7:0] ix, input logic [31:0] e);
    acc(1'b0, ix, 4'hf, 32'h0);
    chk(nm, e, rdat);
  endtask : rd
  // Fault pulses are looked at mid-cycle, after the edge that took the sample
  task automatic conv(input logic a, input pinthr_sample_t r, input logic [2:0] e);
    caux <= a;
    cres <= r;
    cv <= 1'b1;
    @(posedge core_clk);
    cv <= 1'b0;
    @(negedge core_clk);
    chk("faults", {29'h0, e}, {29'h0, cuf, cof, auf});
    @(posedge core_clk);
  endtask : conv
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("oe_b", 32'h3f, poe_b);
    chk("lvl_u", 700, lvl_u);
    chk("lvl_o", 2000, lvl_o);
    $display("test reset done");
    acc(1'b1, 8'h78, 4'h1, 32'h3f);
    rd("dir", 8'h78, 32'h3f);
    chk("oe_b", 0, poe_b);
    acc(1'b1, 8'h79, 4'h1, 32'h15);
    chk("out", 32'h15, pout);
    // Pull-up and pull-down never set on the same pin
    acc(1'b1, 8'h7a, 4'h1, 32'h2a);
    chk("pullup", 32'h2a, pup);
    acc(1'b1, 8'h7b, 4'h1, 32'h15);
    chk("pulldown", 32'h15, pdn);
    pin_in <= 6'h2d;
    repeat (3) @(posedge core_clk);
    rd("in", 8'h7c, 32'h2d);
    $display("test pins done");
    acc(1'b1, 8'h7d, 4'h1, 32'h41);
    repeat (4) @(posedge core_clk);
    rd("fstat", 8'h63, 32'h01);
    chk("oe_b", 0, poe_b);
    rd("fsetup", 8'h7d, 32'h41);
    pin_in <= 6'h2c;
    repeat (4) @(posedge core_clk);
    acc(1'b1, 8'h63, 4'h1, 32'h01);
    rd("fstat", 8'h63, 32'h0);
    acc(1'b1, 8'h7d, 4'h1, 32'h02);
    repeat (4) @(posedge core_clk);
    rd("fstat", 8'h63, 32'h02);
    $display("test faults done");
    rd("key", 8'h82, 32'h0);
    acc(1'b1, 8'h82, 4'hf, KEY ^ 32'h1);
    chk("unl", 0, unl);
    acc(1'b1, 8'h82, 4'hf, KEY);
    chk("unl", 1, unl);
    rd("key", 8'h82, 32'h0);
    acc(1'b1, 8'h82, 4'h7, KEY);
    chk("unl", 0, unl);
    $display("test key done");
    for (int i = 0; i < 4; i++) begin
      s = i[0];
      c = i[1] ? 7'h7f : 7'h05;
      acc(1'b1, 8'h8c, 4'h1, {24'h0, c, s});
      acc(1'b1, 8'h8d, 4'h1, {24'h0, c, s});
      chk("lvl_u", (s ? 2000 : 700) + 25 * c, lvl_u);
      chk("lvl_o", (s ? 700 : 2000) + 25 * c, lvl_o);
      rd("cmp", 8'h8d, {24'h0, c, s});
    end
    $display("test comparators done");
    acc(1'b1, 8'h8e, 4'h3, 32'h4000);
    acc(1'b1, 8'h90, 4'h3, 32'hc000);
    acc(1'b1, 8'h92, 4'h3, 32'h8000);
    rd("cell_u", 8'h8e, 32'h4000);
    rd("cell_o", 8'h90, 32'hc000);
    rd("aux_u", 8'h92, 32'h8000);
    conv(1'b0, 16'h3fff, 3'b100);
    conv(1'b0, 16'h4000, 3'b000);
    conv(1'b0, 16'hc001, 3'b010);
    conv(1'b0, 16'hc000, 3'b000);
    conv(1'b1, 16'h7fff, 3'b001);
    conv(1'b1, 16'h8000, 3'b000);
    rd("unmapped", 8'h10, 32'h0);
    $display("test thresholds done");
    tally_and_finish();
  end
endmodule : pinthr_regs_test
